/* File: verilog/twm_pkg.sv */
// Purpose: Shared constants and types for the two-wire master block
// Assumes: 40 MHz system clock, plain register port
// Notes:   Status codes always read with their three low bits as zero
package twm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] TWM_OFF_CTRL   = 2'h0;
    localparam logic [1:0] TWM_OFF_STATUS = 2'h1;
    localparam logic [1:0] TWM_OFF_DATA   = 2'h2;
    localparam logic [1:0] TWM_OFF_DIV    = 2'h3;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int TWM_B_DONE  = 7;
    localparam int TWM_B_ACK   = 6;
    localparam int TWM_B_START = 5;
    localparam int TWM_B_STOP  = 4;
    localparam int TWM_B_WCOL  = 3;
    localparam int TWM_B_EN    = 2;
    localparam int TWM_B_IRQ   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TWM_RST_CTRL = 8'h00;
    localparam logic [7:0] TWM_RST_DATA = 8'hff;
    localparam logic [7:0] TWM_RST_DIV  = 8'h31;

    // ------------------------------------------------------------
    // Status codes
    // ------------------------------------------------------------
    localparam logic [7:0] TWM_ST_START   = 8'h08;
    localparam logic [7:0] TWM_ST_RSTART  = 8'h10;
    localparam logic [7:0] TWM_ST_AW_ACK  = 8'h18;
    localparam logic [7:0] TWM_ST_AW_NACK = 8'h20;
    localparam logic [7:0] TWM_ST_TX_ACK  = 8'h28;
    localparam logic [7:0] TWM_ST_TX_NACK = 8'h30;
    localparam logic [7:0] TWM_ST_ARB     = 8'h38;
    localparam logic [7:0] TWM_ST_AR_ACK  = 8'h40;
    localparam logic [7:0] TWM_ST_AR_NACK = 8'h48;
    localparam logic [7:0] TWM_ST_RX_ACK  = 8'h50;
    localparam logic [7:0] TWM_ST_RX_NACK = 8'h58;
    localparam logic [7:0] TWM_ST_IDLE    = 8'hf8;

    // ------------------------------------------------------------
    // Timing: bus free time before a START
    // ------------------------------------------------------------
    localparam int TWM_CLK_MHZ     = 40;
    localparam int TWM_T_FREE_NS   = 4700;
    localparam int TWM_FREE_CYCLES = (TWM_T_FREE_NS * TWM_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } twm_bus_s;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } twm_pins_s;

endpackage : twm_pkg

/* File: verilog/twm_master.sv */
// Purpose: Status-driven master of a byte-oriented two-wire bus
// Assumes: One 40 MHz clock, bus pins sampled through three flops
// Notes:   Slave modes are not built; lost arbitration just releases
`timescale 1ns/100ps
module twm_master
    import twm_pkg::*;
#(
    parameter int FREE_CYCLES = TWM_FREE_CYCLES
) (
    input  wire logic              CLOCK,
    input  wire logic              RESET,
    input  wire twm_pkg::twm_bus_s BUS,
    output logic [7:0]             RDATA,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output twm_pkg::twm_pins_s     PINS,
    output logic                   IRQ
);
    import twm_pkg::*;

    initial begin
        if (FREE_CYCLES < 1 || FREE_CYCLES > 65535)
            $error("FREE_CYCLES out of range");
    end

    typedef enum {
        S_IDLE, S_WAITFREE, S_START, S_BIT, S_ACKBIT, S_HOLD,
        S_STOP, S_ARBLOST
    } twm_state_e;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q;       // done,ack,start,stop,wcol,en,-,irq
    logic [7:0]  status_q;
    logic [7:0]  data_q;
    logic [7:0]  div_q;
    logic [7:0]  divcnt_q;
    logic        tick;
    logic [2:0]  scl_s_q;
    logic [2:0]  sda_s_q;
    logic        scl_f_q;
    logic        sda_f_q;
    logic [15:0] free_q;
    logic        bus_free;
    twm_state_e  st_q;
    logic [1:0]  ph_q;         // quarter phase of one bit
    logic [3:0]  bit_q;
    logic        rx_q;         // master receive mode
    logic        addr_q;       // current byte is an address
    logic        sda_out_q;
    logic        scl_out_q;
    logic        restart_q;    // repeated START without a STOP
    logic        set_done;
    logic [7:0]  set_code;
    logic        clr_stop;
    logic        wr_ctrl;
    logic        wr_data;
    logic        go;

    assign wr_ctrl = BUS.wr && BUS.addr == TWM_OFF_CTRL;
    assign wr_data = BUS.wr && BUS.addr == TWM_OFF_DATA;
    // resume on clear
    // A set still in flight counts as set, so the engine never runs on
    assign go = ctrl_q[TWM_B_EN] && !ctrl_q[TWM_B_DONE] && !set_done;

    // ------------------------------------------------------------
    // Pin synchronisers and bus-free detector
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            scl_s_q    <= 3'h7;
            sda_s_q    <= 3'h7;
            scl_f_q    <= 1'b1;
            sda_f_q    <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], SCL_I};
            sda_s_q <= {sda_s_q[1:0], SDA_I};
            if (scl_s_q[1] == scl_s_q[2])
                scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2])
                sda_f_q <= sda_s_q[2];
        end
    end

    // Counts idle-high time; any START by others resets it
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            free_q <= 16'h0000;
        end else if (!scl_f_q || !sda_f_q) begin
            free_q <= 16'h0000;
        end else if (free_q < 16'(FREE_CYCLES)) begin
            free_q <= free_q + 16'h0001;
        end
    end
    assign bus_free = free_q >= 16'(FREE_CYCLES);

    // ------------------------------------------------------------
    // Quarter-bit enable divider
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET || divcnt_q == 8'h00) begin
            divcnt_q <= RESET ? TWM_RST_DIV : div_q;
        end else begin
            divcnt_q <= divcnt_q - 8'h01;
        end
    end
    assign tick = divcnt_q == 8'h00;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ctrl_q <= TWM_RST_CTRL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q[TWM_B_DONE]  <= ctrl_q[TWM_B_DONE]
                                       && !BUS.wdata[TWM_B_DONE];
                ctrl_q[TWM_B_ACK]   <= BUS.wdata[TWM_B_ACK];
                ctrl_q[TWM_B_START] <= BUS.wdata[TWM_B_START];
                ctrl_q[TWM_B_STOP]  <= BUS.wdata[TWM_B_STOP];
                ctrl_q[TWM_B_EN]    <= BUS.wdata[TWM_B_EN];
                ctrl_q[TWM_B_IRQ]   <= BUS.wdata[TWM_B_IRQ];
            end
            if (clr_stop)
                ctrl_q[TWM_B_STOP] <= 1'b0;
            if (wr_data)
                ctrl_q[TWM_B_WCOL] <= !ctrl_q[TWM_B_DONE];
            // Set wins over a clear in the same cycle
            if (set_done)
                ctrl_q[TWM_B_DONE] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status and divider registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            div_q    <= TWM_RST_DIV;
            status_q <= TWM_ST_IDLE;
        end else begin
            if (BUS.wr && BUS.addr == TWM_OFF_DIV)
                div_q <= BUS.wdata;
            if (set_done)
                status_q <= {set_code[7:3], 3'h0};
            // Code holds while the flag is up, even when idle
            else if ((st_q == S_IDLE || st_q == S_WAITFREE)
                     && !ctrl_q[TWM_B_DONE])
                status_q <= TWM_ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Read port, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (BUS.rd) begin
            case (BUS.addr)
                TWM_OFF_CTRL:   RDATA <= {ctrl_q[7:2], 1'b0, ctrl_q[0]};
                TWM_OFF_STATUS: RDATA <= status_q;
                TWM_OFF_DATA:   RDATA <= data_q;
                TWM_OFF_DIV:    RDATA <= div_q;
                default:        RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET)
            IRQ <= 1'b0;
        else
            IRQ <= ctrl_q[TWM_B_DONE] && ctrl_q[TWM_B_IRQ];
    end

    // ------------------------------------------------------------
    // Bus engine: quarter phases 0..3 per bit
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            st_q      <= S_IDLE;
            ph_q      <= 2'h0;
            bit_q     <= 4'h0;
            rx_q      <= 1'b0;
            addr_q    <= 1'b0;
            sda_out_q <= 1'b1;
            scl_out_q <= 1'b1;
            restart_q <= 1'b0;
            data_q    <= TWM_RST_DATA;
            set_done  <= 1'b0;
            set_code  <= TWM_ST_IDLE;
            clr_stop  <= 1'b0;
        end else begin
            set_done <= 1'b0;
            clr_stop <= 1'b0;
            if (wr_data && ctrl_q[TWM_B_DONE])
                data_q <= BUS.wdata;
            if (!ctrl_q[TWM_B_EN]) begin
                st_q      <= S_IDLE;
                sda_out_q <= 1'b1;
                scl_out_q <= 1'b1;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        if (go && ctrl_q[TWM_B_START])
                            st_q <= S_WAITFREE;
                    end
                    S_WAITFREE: begin
                        if (bus_free && tick) begin
                            st_q      <= S_START;
                            ph_q      <= 2'h0;
                            restart_q <= 1'b0;
                        end
                    end
                    S_START: if (tick) begin
                        // Repeated START: release SDA with SCL low first
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_out_q <= 1'b1;
                            2'h1: scl_out_q <= 1'b1;
                            2'h2: sda_out_q <= 1'b0;
                            default: begin
                                scl_out_q <= 1'b0;
                                set_code  <= restart_q ? TWM_ST_RSTART
                                                       : TWM_ST_START;
                                set_done  <= 1'b1;
                                addr_q    <= 1'b1;
                                st_q      <= S_HOLD;
                            end
                        endcase
                    end
                    S_HOLD: begin
                        if (go && ctrl_q[TWM_B_STOP]) begin
                            st_q     <= S_STOP;
                            ph_q     <= 2'h0;
                            clr_stop <= 1'b1;
                        end else if (go && ctrl_q[TWM_B_START]
                                     && !addr_q) begin
                            st_q      <= S_START;
                            ph_q      <= 2'h0;
                            restart_q <= 1'b1;
                        end else if (go) begin
                            if (addr_q)
                                rx_q <= data_q[0];
                            st_q  <= S_BIT;
                            ph_q  <= 2'h0;
                            bit_q <= 4'h0;
                        end
                    end
                    S_BIT: if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_out_q <= (rx_q && !addr_q) ? 1'b1
                                               : data_q[3'h7 - bit_q[2:0]];
                            2'h1: scl_out_q <= 1'b1;
                            2'h2: begin
                                if (rx_q && !addr_q)
                                    data_q <= {data_q[6:0], sda_f_q};
                                else if (sda_out_q && !sda_f_q)
                                    st_q <= S_ARBLOST;
                            end
                            default: begin
                                scl_out_q <= 1'b0;
                                bit_q     <= bit_q + 4'h1;
                                if (bit_q == 4'h7)
                                    st_q <= S_ACKBIT;
                            end
                        endcase
                    end
                    S_ACKBIT: if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_out_q <= (rx_q && !addr_q)
                                             ? !ctrl_q[TWM_B_ACK] : 1'b1;
                            2'h1: scl_out_q <= 1'b1;
                            2'h2: begin
                                if (rx_q && !addr_q)
                                    set_code <= sda_out_q ? TWM_ST_RX_NACK
                                                          : TWM_ST_RX_ACK;
                                else if (addr_q && rx_q)
                                    set_code <= sda_f_q ? TWM_ST_AR_NACK
                                                        : TWM_ST_AR_ACK;
                                else if (addr_q)
                                    set_code <= sda_f_q ? TWM_ST_AW_NACK
                                                        : TWM_ST_AW_ACK;
                                else
                                    set_code <= sda_f_q ? TWM_ST_TX_NACK
                                                        : TWM_ST_TX_ACK;
                            end
                            default: begin
                                // SDA left alone: no edge as SCL falls
                                scl_out_q <= 1'b0;
                                set_done  <= 1'b1;
                                addr_q    <= 1'b0;
                                st_q      <= S_HOLD;
                            end
                        endcase
                    end
                    S_STOP: if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_out_q <= 1'b0;
                            2'h1: scl_out_q <= 1'b1;
                            2'h2: sda_out_q <= 1'b1;
                            default: begin
                                st_q <= ctrl_q[TWM_B_START] ? S_WAITFREE
                                                            : S_IDLE;
                            end
                        endcase
                    end
                    S_ARBLOST: begin
                        sda_out_q <= 1'b1;
                        scl_out_q <= 1'b1;
                        set_code  <= TWM_ST_ARB;
                        set_done  <= 1'b1;
                        st_q      <= S_IDLE;
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers: open-drain, enable while pulling low
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PINS <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
        end else begin
            PINS.scl_o  <= 1'b0;
            PINS.sda_o  <= 1'b0;
            PINS.scl_oe <= !scl_out_q;
            PINS.sda_oe <= !sda_out_q;
        end
    end

endmodule : twm_master

/* File: verification/twm_master_props.sv */
// Purpose: Port assertions for the two-wire master
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every master instance below
`timescale 1ns/100ps
module twm_master_props
    import twm_pkg::*;
#(
    parameter int FREE_CYCLES = TWM_FREE_CYCLES
) (
    input wire logic               CLOCK,
    input wire logic               RESET,
    input wire twm_pkg::twm_bus_s  BUS,
    input wire logic [7:0]         RDATA,
    input wire logic               SCL_I,
    input wire logic               SDA_I,
    input wire twm_pkg::twm_pins_s PINS,
    input wire logic               IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Decoded control accesses and config bits
    wire logic       rd_ctl = BUS.rd && BUS.addr == TWM_OFF_CTRL;
    wire logic       wr_ctl = BUS.wr && BUS.addr == TWM_OFF_CTRL;
    wire logic [2:0] wcfg = {BUS.wdata[6], BUS.wdata[2], BUS.wdata[0]};
    property p_idle; !$past(BUS.rd) |-> RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_code; $past(BUS.rd && BUS.addr == TWM_OFF_STATUS)
        |-> RDATA[2:0] == 3'h0; endproperty
    a_code: assert property (p_code) else $error("status low bits");
    property p_irq; $past(rd_ctl) |-> IRQ == (RDATA[7] & RDATA[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_od; PINS.scl_o == 1'b0 && PINS.sda_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_ctl; wr_ctl ##2 rd_ctl
        |-> ##1 {RDATA[6], RDATA[2], RDATA[0]} == $past(wcfg, 3); endproperty
    a_ctl: assert property (p_ctl) else $error("control bits");
    property p_stop; wr_ctl && BUS.wdata[4] && !BUS.wdata[5]
        |-> ##[1:1000] !PINS.scl_oe && !PINS.sda_oe; endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_off; wr_ctl && !BUS.wdata[2]
        |-> ##[1:3] !PINS.scl_oe && !PINS.sda_oe; endproperty
    a_off: assert property (p_off) else $error("lines held when off");
    property p_rst; $fell(RESET)
        |-> !IRQ && !PINS.scl_oe && !PINS.sda_oe; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
endmodule : twm_master_props
bind twm_master twm_master_props #(.FREE_CYCLES(FREE_CYCLES))
    i_twm_master_props (.CLOCK(CLOCK), .RESET(RESET), .BUS(BUS),
    .RDATA(RDATA), .SCL_I(SCL_I), .SDA_I(SDA_I), .PINS(PINS), .IRQ(IRQ));

/* File: verification/twm_slave_model.sv */
// Purpose: Behavioural slave on the two-wire bus
// Assumes: Open-drain lines with pull-ups, wire levels as inputs
// Notes:   Sends a5 then 11 more per byte; refuses data byte ff
`timescale 1ns/100ps
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic   scl,
    input wire logic   sda,
    output logic       sda_pull,
    output logic [7:0] rx_byte
);
    logic [7:0] tx_q;
    logic       act = 1'b0, rd, sel, first, mack;
    int         n = 0;
    initial sda_pull = 1'b0;
    // START and STOP while the clock line is high
    always @(negedge sda) if (scl) begin
        {act, first, sel, rd} = 4'b1100;
        n = 0;
        tx_q = 8'ha5;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    // Sample bits and the master's acknowledge
    always @(posedge scl) if (act) begin
        if (n < 8) rx_byte = {rx_byte[6:0], sda};
        else mack = !sda;
        n = n + 1;
    end
    // Drive acknowledge or read data while the clock is low
    always @(negedge scl) if (act) begin
        sda_pull = 1'b0;
        if (n == 8) begin
            if (first) {sel, rd} = {rx_byte[7:1] == ADDR, rx_byte[0]};
            sda_pull = sel && (first || (!rd && rx_byte != 8'hff));
        end else if (n == 9) begin
            n = 0;
            if (sel && rd && !first && mack) tx_q = tx_q + 8'h11;
            if (sel && rd && (first || mack)) sda_pull = !tx_q[7];
            else if (sel && rd) act = 1'b0;
            first = 1'b0;
        end else if (n < 8)
            sda_pull = sel && rd && !first && !tx_q[7-n];
    end
endmodule : twm_slave_model

/* File: verification/twm_master_test.sv */
// Purpose: Register-level test of the two-wire master
// Assumes: Pull-ups on both lines, divider 4, short free time
// Notes:   One slave model at address 2a
`timescale 1ns/100ps
`define CHK(nm, exp, seen) begin checks_done++; \
    if ((seen) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, exp, seen); end end
module twm_master_test;
    import twm_pkg::*;
    localparam logic [7:0] SLV = 8'h54;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    twm_bus_s   bus = '0;
    twm_pins_s  pins;
    logic [7:0] rdata, rx_byte, got;
    logic       irq, sda_pull, scl, sda;
    int         err_total = 0;
    int         checks_done = 0;
    always #12.5 clk = ~clk;
    // Open-drain lines with pull-ups
    assign scl = !pins.scl_oe;
    assign sda = !(pins.sda_oe || sda_pull);
    twm_master #(.FREE_CYCLES(4)) i_twm_master (.CLOCK(clk), .RESET(rst),
        .BUS(bus), .RDATA(rdata), .SCL_I(scl), .SDA_I(sda), .PINS(pins),
        .IRQ(irq));
    twm_slave_model i_twm_slave_model (.scl(scl), .sda(sda),
        .sda_pull(sda_pull), .rx_byte(rx_byte));
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rchk(string nm, logic [1:0] a, logic [7:0] m, e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 got = rdata;
        if (nm != "") `CHK(nm, e, got & m)
    endtask : rchk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Write control, poll for the done flag, compare status
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        wr(TWM_OFF_CTRL, c);
        for (int i = 0; i < 300; i++) begin
            rchk("", TWM_OFF_CTRL, 8'hff, 8'h00);
            if (got[TWM_B_DONE] === 1'b1) break;
            if (i == 299) begin
                err_total++;
                final_report();
            end
        end
        rchk("status", TWM_OFF_STATUS, 8'hff, st);
    endtask : step
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rchk("ctrl", TWM_OFF_CTRL, 8'hff, TWM_RST_CTRL);
        rchk("status", TWM_OFF_STATUS, 8'hff, TWM_ST_IDLE);
        rchk("div", TWM_OFF_DIV, 8'hff, TWM_RST_DIV);
        // Five clocks a quarter bit, longer than the pin synchroniser lag
        wr(TWM_OFF_DIV, 8'h04);
        wr(TWM_OFF_DATA, 8'h77);
        rchk("wcol", TWM_OFF_CTRL, 8'h08, 8'h08);
        rchk("data", TWM_OFF_DATA, 8'hff, TWM_RST_DATA);
        $display("test registers done");
        step(8'ha5, TWM_ST_START);
        `CHK("irq", 1'b1, irq)
        wr(TWM_OFF_DATA, SLV | 8'h01);
        rchk("wcol", TWM_OFF_CTRL, 8'h08, 8'h00);
        step(8'hc5, TWM_ST_AR_ACK);
        repeat (40) @(posedge clk);
        `CHK("hold", 1'b1, pins.scl_oe)
        step(8'hc5, TWM_ST_RX_ACK);
        rchk("rx0", TWM_OFF_DATA, 8'hff, 8'ha5);
        step(8'h85, TWM_ST_RX_NACK);
        rchk("rx1", TWM_OFF_DATA, 8'hff, 8'hb6);
        $display("test receive done");
        step(8'ha5, TWM_ST_RSTART);
        wr(TWM_OFF_DATA, SLV);
        step(8'h85, TWM_ST_AW_ACK);
        wr(TWM_OFF_DATA, 8'h3c);
        step(8'h85, TWM_ST_TX_ACK);
        `CHK("sent", 8'h3c, rx_byte)
        wr(TWM_OFF_DATA, 8'hff);
        step(8'h85, TWM_ST_TX_NACK);
        step(8'hb5, TWM_ST_START);
        rchk("stop", TWM_OFF_CTRL, 8'h10, 8'h00);
        wr(TWM_OFF_DATA, SLV + 8'h03);
        step(8'h85, TWM_ST_AR_NACK);
        wr(TWM_OFF_CTRL, 8'h95);
        repeat (60) @(posedge clk);
        rchk("stop", TWM_OFF_CTRL, 8'h10, 8'h00);
        `CHK("sda", 1'b1, sda)
        rchk("idle", TWM_OFF_STATUS, 8'hff, TWM_ST_IDLE);
        wr(TWM_OFF_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        `CHK("off", 1'b0, pins.scl_oe | pins.sda_oe)
        $display("test transmit done");
        final_report();
    end
endmodule : twm_master_test
